// [hdl/uepc_top.sv]
// endpoint 0 and IN endpoint 1-5 control/status with APB register access
`timescale 1ns/1ps
module uepc_top (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [uepc_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic PREADY,
	output logic [31:0] PRDATA,
	output logic PSLVERR,
	input wire uepc_pkg::uepc_ev_t USB_EV,
	output uepc_pkg::uepc_rsp_t USB_RSP,
	output logic [5:0] INT_REQ,
	output logic [5:0] FIFO_FLUSH,
	output logic [5:1] PKT_DROP
);
	logic rst_meta_r;
	logic rst_n;
	logic pready_r;
	logic pslverr_r;
	logic [7:0] prdata_r;
	logic [3:0] index_r;
	logic [7:0] maxp_r [1:5];
	logic [5:1] iso_r;
	logic [5:1] tog_r;
	logic [5:1] sent_stall_r;
	logic [5:1] send_stall_r;
	logic [5:1] under_r;
	logic [5:1] tx_rdy_r;
	logic [1:0] pkt_cnt_r [1:5];
	logic setup_end_r;
	logic rx_rdy0_r;
	logic send_stall0_r;
	logic sent_stall0_r;
	logic data_end_r;
	logic tx_rdy0_r;
	uepc_pkg::uepc_rsp_t rsp_r;
	uepc_pkg::uepc_rsp_t rsp_nxt;
	logic [5:0] int_r;
	logic [5:0] flush_r;
	logic [5:1] drop_r;
	logic [15:0] widx;
	logic hit_sel;
	logic hit_max;
	logic hit_cs;
	logic hit_ctlh;
	logic mapped;
	logic commit;
	logic wr_sel;
	logic wr_max;
	logic wr_cs;
	logic wr_ctlh;
	logic [2:0] sel;
	logic sel_ep0;
	logic in_sel;
	logic [7:0] wd;
	logic [7:0] rd_val;
	logic ev_in;
	logic ev0_tok;
	logic ev0_ack;
	logic ev0_rx;
	logic ev0_stall;
	logic [5:1] wr_in;
	logic [5:1] in_hit;
	logic [5:1] ack_hit;
	logic [5:1] load_hit;
	logic [5:1] stall_eff;
	logic [5:1] stall_snd;
	logic [5:1] empty_hit;
	logic [5:1] flush_one;

	// reset asserts asynchronously, releases synchronously
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	assign widx = PADDR[uepc_pkg::ADDR_W-1:2];
	assign hit_sel = (widx == uepc_pkg::IDX_SEL);
	assign hit_max = (widx == uepc_pkg::IDX_MAXP);
	assign hit_cs = (widx == uepc_pkg::IDX_CS);
	assign hit_ctlh = (widx == uepc_pkg::IDX_CTLH);
	assign mapped = (PADDR[1:0] == 2'h0) && (hit_sel || hit_max || hit_cs || hit_ctlh);
	// writes land on the edge where the master sees PREADY high
	assign commit = PSEL && PENABLE && pready_r && PWRITE && mapped;
	assign wr_sel = commit && hit_sel;
	assign wr_max = commit && hit_max;
	assign wr_cs = commit && hit_cs;
	assign wr_ctlh = commit && hit_ctlh;
	assign wd = PWDATA[7:0];
	assign sel = index_r[2:0];
	assign sel_ep0 = (index_r == 4'h0);
	assign in_sel = (index_r != 4'h0) && (index_r <= {1'b0, uepc_pkg::EP_LAST});

	assign ev_in = (USB_EV.ep != 3'h0) && (USB_EV.ep <= uepc_pkg::EP_LAST);
	assign ev0_tok = USB_EV.in_tok && (USB_EV.ep == 3'h0);
	assign ev0_ack = USB_EV.ack && (USB_EV.ep == 3'h0);
	assign ev0_rx = USB_EV.rx_pkt && (USB_EV.ep == 3'h0);
	assign ev0_stall = ev0_tok && send_stall0_r;

	always_comb begin
		for (int e = 1; e <= 5; e++) begin
			wr_in[e] = wr_cs && (index_r == 4'(e));
			in_hit[e] = USB_EV.in_tok && (USB_EV.ep == 3'(e));
			ack_hit[e] = USB_EV.ack && (USB_EV.ep == 3'(e));
			load_hit[e] = USB_EV.load && (USB_EV.ep == 3'(e));
			stall_eff[e] = send_stall_r[e] && !iso_r[e];
			stall_snd[e] = in_hit[e] && stall_eff[e];
			empty_hit[e] = in_hit[e] && !stall_eff[e] && !tx_rdy_r[e];
			flush_one[e] = wr_in[e] && wd[uepc_pkg::BI_FLUSH];
		end
	end

	// APB slave: one wait state, PSLVERR on unmapped or misaligned
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 8'h00;
		end else begin
			pready_r <= PSEL && PENABLE && !pready_r;
			pslverr_r <= PSEL && PENABLE && !pready_r && !mapped;
			if (PSEL && PENABLE && !pready_r) begin
				prdata_r <= PWRITE ? 8'h00 : rd_val;
			end
		end
	end

	always_comb begin
		rd_val = 8'h00;
		if (hit_sel) begin
			rd_val = {4'h0, index_r};
		end else if (hit_max && in_sel) begin
			rd_val = maxp_r[sel];
		end else if (hit_ctlh && in_sel) begin
			rd_val[uepc_pkg::BH_ISO] = iso_r[sel];
		end else if (hit_cs && sel_ep0) begin
			rd_val[uepc_pkg::B0_STALL] = send_stall0_r;
			rd_val[uepc_pkg::B0_PEND] = setup_end_r;
			rd_val[uepc_pkg::B0_DEND] = data_end_r;
			rd_val[uepc_pkg::B0_SENT] = sent_stall0_r;
			rd_val[uepc_pkg::B0_TXRDY] = tx_rdy0_r;
			rd_val[uepc_pkg::B0_RXRDY] = rx_rdy0_r;
		end else if (hit_cs && in_sel) begin
			// bit 7 stays zero
			rd_val[uepc_pkg::BI_SENT] = sent_stall_r[sel];
			rd_val[uepc_pkg::BI_STALL] = send_stall_r[sel];
			rd_val[uepc_pkg::BI_UNDER] = under_r[sel];
			rd_val[uepc_pkg::BI_PRESENT] = (pkt_cnt_r[sel] != 2'h0);
			rd_val[uepc_pkg::BI_TXRDY] = tx_rdy_r[sel];
		end
	end

	// index and per-endpoint configuration
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			index_r <= uepc_pkg::RST_INDEX;
			iso_r <= '0;
			for (int e = 1; e <= 5; e++) begin
				maxp_r[e] <= uepc_pkg::RST_MAXP;
			end
		end else begin
			if (wr_sel) begin
				index_r <= wd[3:0];
			end
			for (int e = 1; e <= 5; e++) begin
				if (wr_max && (index_r == 4'(e))) begin
					maxp_r[e] <= wd;
				end
				if (wr_ctlh && (index_r == 4'(e))) begin
					iso_r[e] <= wd[uepc_pkg::BH_ISO];
				end
			end
		end
	end

	// endpoint 0 handshake flags; hardware sets win over firmware clears
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			setup_end_r <= 1'b0;
			rx_rdy0_r <= 1'b0;
			send_stall0_r <= 1'b0;
			sent_stall0_r <= 1'b0;
			data_end_r <= 1'b0;
			tx_rdy0_r <= 1'b0;
		end else begin
			if (wr_cs && sel_ep0 && wd[uepc_pkg::B0_CLR_END]) begin
				setup_end_r <= 1'b0;
			end
			if (USB_EV.setup_end) begin
				setup_end_r <= 1'b1;
			end
			if (wr_cs && sel_ep0 && wd[uepc_pkg::B0_CLR_RX]) begin
				rx_rdy0_r <= 1'b0;
			end
			if (ev0_rx) begin
				rx_rdy0_r <= 1'b1;
			end
			if (ev0_stall) begin
				send_stall0_r <= 1'b0;
			end
			if (wr_cs && sel_ep0 && wd[uepc_pkg::B0_STALL]) begin
				send_stall0_r <= 1'b1;
			end
			if (wr_cs && sel_ep0 && !wd[uepc_pkg::B0_SENT]) begin
				sent_stall0_r <= 1'b0;
			end
			if (ev0_stall) begin
				sent_stall0_r <= 1'b1;
			end
			// data end is consumed by the acknowledged last packet or an aborted transfer
			if (ev0_ack || USB_EV.setup_end) begin
				data_end_r <= 1'b0;
			end
			if (wr_cs && sel_ep0 && wd[uepc_pkg::B0_DEND]) begin
				data_end_r <= 1'b1;
			end
			if (ev0_ack || USB_EV.setup_end) begin
				tx_rdy0_r <= 1'b0;
			end
			if (wr_cs && sel_ep0 && wd[uepc_pkg::B0_TXRDY]) begin
				tx_rdy0_r <= 1'b1;
			end
		end
	end

	// IN endpoint 1-5 flags, toggle and packet occupancy
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tog_r <= '0;
			sent_stall_r <= '0;
			send_stall_r <= '0;
			under_r <= '0;
			tx_rdy_r <= '0;
			for (int e = 1; e <= 5; e++) begin
				pkt_cnt_r[e] <= 2'h0;
			end
		end else begin
			for (int e = 1; e <= 5; e++) begin
				if (wr_in[e] && wd[uepc_pkg::BI_TOG]) begin
					tog_r[e] <= 1'b0;
				end else if (ack_hit[e]) begin
					tog_r[e] <= ~tog_r[e];
				end
				if (wr_in[e]) begin
					send_stall_r[e] <= wd[uepc_pkg::BI_STALL];
				end
				if (wr_in[e] && !wd[uepc_pkg::BI_SENT]) begin
					sent_stall_r[e] <= 1'b0;
				end
				if (stall_snd[e]) begin
					sent_stall_r[e] <= 1'b1;
				end
				if (wr_in[e] && !wd[uepc_pkg::BI_UNDER]) begin
					under_r[e] <= 1'b0;
				end
				if (empty_hit[e]) begin
					under_r[e] <= 1'b1;
				end
				// a fresh ready from firmware outlives the ack of the previous packet
				if (ack_hit[e] || stall_snd[e] || flush_one[e]) begin
					tx_rdy_r[e] <= 1'b0;
				end
				if (wr_in[e] && wd[uepc_pkg::BI_TXRDY] && !wd[uepc_pkg::BI_FLUSH]) begin
					tx_rdy_r[e] <= 1'b1;
				end
				if (stall_snd[e]) begin
					pkt_cnt_r[e] <= 2'h0;
				end else begin
					pkt_cnt_r[e] <= 2'(pkt_cnt_r[e]
						+ {1'b0, load_hit[e] && (pkt_cnt_r[e] != uepc_pkg::PKT_MAX)}
						- {1'b0, (ack_hit[e] || flush_one[e]) && (pkt_cnt_r[e] != 2'h0)});
				end
			end
		end
	end

	// handshake choice for each IN token
	always_comb begin
		rsp_nxt.valid = USB_EV.in_tok && (ev_in || USB_EV.ep == 3'h0);
		rsp_nxt.ep = USB_EV.ep;
		rsp_nxt.toggle = 1'b0;
		rsp_nxt.kind = uepc_pkg::UEPC_HS_NAK;
		if (USB_EV.ep == 3'h0) begin
			if (send_stall0_r) begin
				rsp_nxt.kind = uepc_pkg::UEPC_HS_STALL;
			end else if (tx_rdy0_r) begin
				rsp_nxt.kind = uepc_pkg::UEPC_HS_DATA;
			end
		end else if (ev_in) begin
			rsp_nxt.toggle = tog_r[USB_EV.ep];
			if (stall_eff[USB_EV.ep]) begin
				rsp_nxt.kind = uepc_pkg::UEPC_HS_STALL;
			end else if (tx_rdy_r[USB_EV.ep]) begin
				rsp_nxt.kind = uepc_pkg::UEPC_HS_DATA;
			end else if (iso_r[USB_EV.ep]) begin
				rsp_nxt.kind = uepc_pkg::UEPC_HS_ZLP;
			end
		end
	end

	// registered event outputs; interrupt masking lives outside this block
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rsp_r <= '0;
			int_r <= 6'h00;
			flush_r <= 6'h00;
			drop_r <= 5'h00;
		end else begin
			rsp_r <= rsp_nxt;
			int_r[0] <= USB_EV.setup_end || ev0_stall || ev0_ack || ev0_rx;
			int_r[5:1] <= ack_hit | stall_snd;
			flush_r <= {stall_snd, USB_EV.setup_end};
			drop_r <= flush_one;
		end
	end

	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign PRDATA = {24'h000000, prdata_r};
	assign USB_RSP = rsp_r;
	assign INT_REQ = int_r;
	assign FIFO_FLUSH = flush_r;
	assign PKT_DROP = drop_r;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	a_stall_reply: assert property (USB_EV.in_tok && ev_in && stall_eff[USB_EV.ep]
		|=> USB_RSP.valid && USB_RSP.kind == uepc_pkg::UEPC_HS_STALL && FIFO_FLUSH[5:1] != 5'h00)
		else $error("stall not answered or not flushed");
	a_stall_flag_set: assert property (USB_EV.in_tok && ev_in && stall_eff[USB_EV.ep]
		|=> sent_stall_r[$past(USB_EV.ep)] && !tx_rdy_r[$past(USB_EV.ep)] && pkt_cnt_r[$past(USB_EV.ep)] == 2'h0)
		else $error("stall side effects missing");
	a_toggle_reset: assert property (wr_cs && in_sel && wd[uepc_pkg::BI_TOG]
		|=> !tog_r[$past(sel)])
		else $error("data toggle not reset");
	a_underrun_mark: assert property (USB_EV.in_tok && ev_in && !stall_eff[USB_EV.ep] && !tx_rdy_r[USB_EV.ep]
		|=> under_r[$past(USB_EV.ep)] && (USB_RSP.kind == (iso_r[USB_RSP.ep] ? uepc_pkg::UEPC_HS_ZLP
		: uepc_pkg::UEPC_HS_NAK)))
		else $error("underrun handshake wrong");
	a_load_present: assert property (USB_EV.load && ev_in && !USB_EV.ack && !USB_EV.in_tok
		|=> pkt_cnt_r[$past(USB_EV.ep)] != 2'h0)
		else $error("loaded packet not counted");
	a_ep0_stall_once: assert property (ev0_stall && !wr_cs
		|=> !send_stall0_r && sent_stall0_r && USB_RSP.kind == uepc_pkg::UEPC_HS_STALL && INT_REQ[0])
		else $error("endpoint 0 stall sequence wrong");
	a_setup_end_abort: assert property (USB_EV.setup_end
		|=> setup_end_r && FIFO_FLUSH[0] && INT_REQ[0] && !tx_rdy0_r)
		else $error("premature end not handled");
	a_clr_end_self: assert property (wr_cs && sel_ep0 && wd[uepc_pkg::B0_CLR_END] && !USB_EV.setup_end
		|=> !setup_end_r)
		else $error("premature end flag not cleared");
	a_ep0_sent_int: assert property (ev0_ack && tx_rdy0_r && !wr_cs
		|=> !tx_rdy0_r && INT_REQ[0] && !data_end_r)
		else $error("endpoint 0 send completion wrong");
	a_reserved_zero: assert property (PSEL && PENABLE && !pready_r && !PWRITE && hit_cs && in_sel
		|=> PREADY && PRDATA[7] == 1'b0)
		else $error("unused status bit read nonzero");
	a_drop_pulse: assert property (wr_cs && in_sel && wd[uepc_pkg::BI_FLUSH]
		|=> PKT_DROP[$past(sel)] && !tx_rdy_r[$past(sel)])
		else $error("packet drop not signalled");
endmodule : uepc_top

// [hdl/uepc_pkg.sv]
// constants and types for the IN endpoint and endpoint 0 control block
package uepc_pkg;
	localparam int ADDR_W = 18;
	localparam logic [15:0] IDX_SEL = 16'hDE0E;
	localparam logic [15:0] IDX_MAXP = 16'hDE10;
	localparam logic [15:0] IDX_CS = 16'hDE11;
	localparam logic [15:0] IDX_CTLH = 16'hDE12;
	localparam int B0_CLR_END = 7;
	localparam int B0_CLR_RX = 6;
	localparam int B0_STALL = 5;
	localparam int B0_PEND = 4;
	localparam int B0_DEND = 3;
	localparam int B0_SENT = 2;
	localparam int B0_TXRDY = 1;
	localparam int B0_RXRDY = 0;
	localparam int BI_TOG = 6;
	localparam int BI_SENT = 5;
	localparam int BI_STALL = 4;
	localparam int BI_FLUSH = 3;
	localparam int BI_UNDER = 2;
	localparam int BI_PRESENT = 1;
	localparam int BI_TXRDY = 0;
	localparam int BH_ISO = 6;
	localparam logic [7:0] RST_MAXP = 8'h00;
	localparam logic [3:0] RST_INDEX = 4'h0;
	localparam logic [1:0] PKT_MAX = 2'h2;
	localparam logic [2:0] EP_LAST = 3'h5;
	typedef enum logic [1:0] {
		UEPC_HS_DATA = 2'b00,
		UEPC_HS_NAK = 2'b01,
		UEPC_HS_STALL = 2'b10,
		UEPC_HS_ZLP = 2'b11
	} uepc_hs_t;
	typedef struct packed {
		logic in_tok;
		logic ack;
		logic load;
		logic setup_end;
		logic rx_pkt;
		logic [2:0] ep;
	} uepc_ev_t;
	typedef struct packed {
		logic valid;
		uepc_hs_t kind;
		logic toggle;
		logic [2:0] ep;
	} uepc_rsp_t;
endpackage : uepc_pkg

// [dv/uepc_host_model.sv]
// host-side model that issues tokens, acks and engine events toward the endpoint block
`timescale 1ns/1ps
module uepc_host_model (
	input wire logic clk,
	output uepc_pkg::uepc_ev_t usb_ev,
	input wire uepc_pkg::uepc_rsp_t usb_rsp,
	input wire logic [5:0] int_req,
	input wire logic [5:0] fifo_flush
);
	uepc_pkg::uepc_rsp_t rsp_q;
	uepc_pkg::uepc_rsp_t tok_q;
	logic [5:0] int_q;
	logic [5:0] fl_q;
	initial begin
		usb_ev = '0;
	end
	// one-cycle event, then snapshot of the registered answers one cycle later
	task pulse(input logic [4:0] k, input logic [2:0] e);
		@(posedge clk);
		usb_ev <= {k, e};
		@(posedge clk);
		usb_ev <= '0;
		@(posedge clk);
		rsp_q = usb_rsp;
		int_q = int_req;
		fl_q = fifo_flush;
	endtask : pulse
	// a host only acks a data packet; gap models a slow host
	task in_xfer(input logic [2:0] e, input int gap);
		pulse(5'h10, e);
		tok_q = rsp_q;
		if (tok_q.valid === 1'b1 && tok_q.kind === uepc_pkg::UEPC_HS_DATA) begin
			repeat (gap) @(posedge clk);
			pulse(5'h08, e);
		end
	endtask : in_xfer
endmodule : uepc_host_model

// [dv/usb_ep0_in_endpoint_control_tb.sv]
// self-checking bench: apb register sequences plus host token traffic
`timescale 1ns/1ps
module usb_ep0_in_endpoint_control_tb;
	localparam logic [15:0] SEL = uepc_pkg::IDX_SEL;
	localparam logic [15:0] MAXP = uepc_pkg::IDX_MAXP;
	localparam logic [15:0] CS = uepc_pkg::IDX_CS;
	localparam logic [15:0] UPR = uepc_pkg::IDX_CTLH;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	uepc_pkg::uepc_ev_t usb_ev;
	uepc_pkg::uepc_rsp_t usb_rsp;
	logic [5:0] int_req;
	logic [5:0] fifo_flush;
	logic [5:1] pkt_drop;
	logic [31:0] rd_q;
	logic err_q;
	int err_count = 0;
	int n_checks = 0;
	always #2 clk = ~clk;
	uepc_top DUT (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .USB_EV(usb_ev),
		.USB_RSP(usb_rsp), .INT_REQ(int_req), .FIFO_FLUSH(fifo_flush), .PKT_DROP(pkt_drop));
	uepc_host_model host (.clk(clk), .usb_ev(usb_ev), .usb_rsp(usb_rsp), .int_req(int_req),
		.fifo_flush(fifo_flush));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// byte address is four times the register index
	task apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [15:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask : wr
	task rd(input logic [15:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd_q, {24'h000000, exp});
	endtask : rd
	task kind(input uepc_pkg::uepc_hs_t k);
		chk(32'({host.tok_q.valid, host.tok_q.kind}), 32'({1'b1, k}));
	endtask : kind
	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#20000;
		err_count++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(SEL, 8'h00);
		wr(SEL, 8'h01);
		rd(MAXP, 8'h00);
		wr(MAXP, 8'h08);
		rd(MAXP, 8'h08);
		wr(SEL, 8'h02);
		rd(MAXP, 8'h00);
		wr(SEL, 8'h00);
		rd(MAXP, 8'h00);
		apb(1'b0, 16'hDE20, 8'h00);
		chk({31'h00000000, err_q}, 32'h00000001);
		rd(CS, 8'h00);
		host.pulse(5'h01, 3'h0);
		chk(32'(host.int_q), 32'h00000001);
		rd(CS, 8'h01);
		wr(CS, 8'h40);
		rd(CS, 8'h00);
		host.pulse(5'h02, 3'h0);
		chk(32'(host.fl_q), 32'h00000001);
		chk(32'(host.int_q), 32'h00000001);
		rd(CS, 8'h10);
		wr(CS, 8'h80);
		rd(CS, 8'h00);
		wr(CS, 8'h20);
		host.in_xfer(3'h0, 0);
		kind(uepc_pkg::UEPC_HS_STALL);
		chk(32'(host.int_q), 32'h00000001);
		rd(CS, 8'h04);
		wr(CS, 8'h00);
		rd(CS, 8'h00);
		host.in_xfer(3'h0, 0);
		kind(uepc_pkg::UEPC_HS_NAK);
		wr(CS, 8'h0A);
		rd(CS, 8'h0A);
		host.in_xfer(3'h0, 3);
		kind(uepc_pkg::UEPC_HS_DATA);
		chk(32'(host.int_q), 32'h00000001);
		rd(CS, 8'h00);
		// endpoint 1, bulk
		wr(SEL, 8'h01);
		rd(CS, 8'h00);
		wr(CS, 8'h80);
		rd(CS, 8'h00);
		host.in_xfer(3'h1, 0);
		kind(uepc_pkg::UEPC_HS_NAK);
		rd(CS, 8'h04);
		host.pulse(5'h04, 3'h1);
		wr(CS, 8'h01);
		rd(CS, 8'h03);
		host.in_xfer(3'h1, 2);
		chk(32'(host.tok_q.toggle), 32'h00000000);
		chk(32'(host.int_q), 32'h00000002);
		rd(CS, 8'h00);
		// toggle is 1 here, so only the reset write can bring DATA0
		host.pulse(5'h04, 3'h1);
		wr(CS, 8'h41);
		host.in_xfer(3'h1, 0);
		chk(32'(host.tok_q.toggle), 32'h00000000);
		host.pulse(5'h04, 3'h1);
		wr(CS, 8'h01);
		host.in_xfer(3'h1, 0);
		chk(32'(host.tok_q.toggle), 32'h00000001);
		// two queued packets need two drop writes
		host.pulse(5'h04, 3'h1);
		host.pulse(5'h04, 3'h1);
		wr(CS, 8'h08);
		@(posedge clk);
		chk(32'(pkt_drop), 32'h00000001);
		rd(CS, 8'h02);
		wr(CS, 8'h08);
		@(posedge clk);
		chk(32'(pkt_drop), 32'h00000001);
		rd(CS, 8'h00);
		host.pulse(5'h04, 3'h1);
		wr(CS, 8'h11);
		host.in_xfer(3'h1, 0);
		kind(uepc_pkg::UEPC_HS_STALL);
		chk(32'(host.fl_q), 32'h00000002);
		chk(32'(host.int_q), 32'h00000002);
		rd(CS, 8'h30);
		wr(CS, 8'h00);
		host.in_xfer(3'h1, 0);
		kind(uepc_pkg::UEPC_HS_NAK);
		// isochronous: stall request is held in the register but no stall is sent
		wr(UPR, 8'h40);
		rd(UPR, 8'h40);
		wr(CS, 8'h10);
		host.in_xfer(3'h1, 0);
		kind(uepc_pkg::UEPC_HS_ZLP);
		rd(CS, 8'h14);
		tally_and_finish;
	end
endmodule : usb_ep0_in_endpoint_control_tb
